/* tbw_bank_ref.sv */
`timescale 1ns/1ps
// ****
// holding bank reference
// ****
module tbw_bank_ref (
   input wire logic clk,
   input wire logic we,
   input wire logic [2:0] sel,
   input wire logic [7:0] d,
   output logic [63:0] bank
);
   initial bank = 64'h0;
   always @(posedge clk) if (we) bank[8*sel +: 8] <= d;
endmodule : tbw_bank_ref

/* tbw_exec.sv */
`timescale 1ns/1ps
// How it works
// - low three pointer bits pick holding register
// - holding registers only stage later flash data
// - pointer is 21-bit program byte address
// - pointer bit zero selects low/high byte
// - keep, post-inc, post-dec or pre-inc pointer
module tbw_exec (
   input wire logic clk,
   input wire logic nrst,
   input wire logic instr_valid,
   input wire logic [15:0] instr_opcode,
   input wire logic [7:0] table_latch_byte,
   input wire logic ptr_load,
   input wire logic [tbw_pkg::PTR_W-1:0] ptr_load_value,
   output logic [tbw_pkg::PTR_W-1:0] table_pointer,
   output logic busy,
   output logic write_done,
   output logic high_byte_sel,
   output logic [8*tbw_pkg::HOLD_N-1:0] hold_bank
);
   // ****************************************
   // reset release
   // ****************************************
   logic [1:0] rst_sync_reg;
   logic rst_n;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      tbw_pkg::tbw_state_t st;
      tbw_pkg::tbw_mode_t mode;
      logic [tbw_pkg::PTR_W-1:0] ptr;
      logic [7:0] data;
      logic wr;
      logic [tbw_pkg::SEL_W-1:0] sel;
      logic busy;
      logic done;
      logic hi;
      logic [8*tbw_pkg::HOLD_N-1:0] bank;
   } tbw_exec_t;

   tbw_exec_t s_reg;
   tbw_exec_t s_next;
   tbw_hold_if hif ();

   // ****************************************
   // instruction decode
   // ****************************************
   function automatic logic is_write(input logic [15:0] op);
      logic upper_ok;
      logic tag_ok;
      upper_ok = op[15:4] == tbw_pkg::OPC_UPPER;
      tag_ok = op[3:2] == tbw_pkg::OPC_WR_TAG;
      return upper_ok && tag_ok;
   endfunction : is_write

   function automatic tbw_pkg::tbw_mode_t mode_of(input logic [15:0] op);
      tbw_pkg::tbw_mode_t m;
      m = tbw_pkg::TBW_KEEP;
      unique case (op[1:0])
         2'h0: begin
            m = tbw_pkg::TBW_KEEP;
         end
         2'h1: begin
            m = tbw_pkg::TBW_POST_INC;
         end
         2'h2: begin
            m = tbw_pkg::TBW_POST_DEC;
         end
         2'h3: begin
            m = tbw_pkg::TBW_PRE_INC;
         end
      endcase
      return m;
   endfunction : mode_of

   // ****************************************
   // pointer arithmetic
   // ****************************************
   function automatic logic [tbw_pkg::PTR_W-1:0] step(input logic [tbw_pkg::PTR_W-1:0] p,
                                                       input logic dec);
      return dec ? p - tbw_pkg::PTR_ONE : p + tbw_pkg::PTR_ONE;
   endfunction : step

   function automatic logic [tbw_pkg::PTR_W-1:0] write_addr(input logic [tbw_pkg::PTR_W-1:0] p,
                                                             input tbw_pkg::tbw_mode_t m);
      logic [tbw_pkg::PTR_W-1:0] a;
      a = p;
      if (m == tbw_pkg::TBW_PRE_INC) begin
         a = step(p, 1'b0);
      end
      return a;
   endfunction : write_addr

   function automatic logic [tbw_pkg::PTR_W-1:0] next_ptr(input logic [tbw_pkg::PTR_W-1:0] p,
                                                           input tbw_pkg::tbw_mode_t m);
      logic [tbw_pkg::PTR_W-1:0] n;
      n = p;
      unique case (m)
         tbw_pkg::TBW_KEEP: begin
            n = p;
         end
         tbw_pkg::TBW_POST_INC: begin
            n = step(p, 1'b0);
         end
         tbw_pkg::TBW_POST_DEC: begin
            n = step(p, 1'b1);
         end
         tbw_pkg::TBW_PRE_INC: begin
            n = write_addr(p, m);
         end
      endcase
      return n;
   endfunction : next_ptr

   function automatic logic [tbw_pkg::SEL_W-1:0] slot_of(input logic [tbw_pkg::PTR_W-1:0] a);
      return a[tbw_pkg::SEL_W-1:0];
   endfunction : slot_of

   function automatic logic is_high(input logic [tbw_pkg::PTR_W-1:0] a);
      return a[0];
   endfunction : is_high

   // ****************************************
   // execute
   // ****************************************
   always_comb begin
      logic [tbw_pkg::PTR_W-1:0] addr;
      logic take;

      addr = s_reg.ptr;
      take = instr_valid && is_write(instr_opcode);
      s_next = s_reg;
      s_next.wr = 1'b0;
      s_next.done = 1'b0;
      s_next.bank = hif.bank;

      unique case (s_reg.st)
         tbw_pkg::TBW_IDLE: begin
            if (ptr_load) begin
               s_next.ptr = ptr_load_value;
            end else if (take) begin
               s_next.mode = mode_of(instr_opcode);
               s_next.data = table_latch_byte;
               s_next.busy = 1'b1;
               s_next.st = tbw_pkg::TBW_EXEC;
            end else begin
               s_next.busy = 1'b0;
            end
         end
         tbw_pkg::TBW_EXEC: begin
            addr = write_addr(s_reg.ptr, s_reg.mode);
            s_next.wr = 1'b1;
            s_next.sel = slot_of(addr);
            s_next.hi = is_high(addr);
            s_next.ptr = next_ptr(s_reg.ptr, s_reg.mode);
            s_next.done = 1'b1;
            s_next.busy = 1'b0;
            s_next.st = tbw_pkg::TBW_IDLE;
         end
         default: begin
            s_next.st = tbw_pkg::TBW_IDLE;
         end
      endcase
   end

   // ****************************************
   // state registers
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '{
            st: tbw_pkg::TBW_IDLE,
            mode: tbw_pkg::TBW_KEEP,
            ptr: tbw_pkg::PTR_RST,
            data: tbw_pkg::BYTE_RST,
            wr: 1'b0,
            sel: '0,
            busy: 1'b0,
            done: 1'b0,
            hi: 1'b0,
            bank: '0
         };
      end else begin
         s_reg <= s_next;
      end
   end

   // ****************************************
   // holding bank feed
   // ****************************************
   assign hif.wr = s_reg.wr;
   assign hif.sel = s_reg.sel;
   assign hif.data = s_reg.data;

   // ****************************************
   // holding bank
   // ****************************************
   tbw_hold_bank u_bank (
      .clk(clk),
      .rst_n(rst_n),
      .hif(hif.hold)
   );

   // ****************************************
   // outputs
   // ****************************************
   assign table_pointer = s_reg.ptr;
   assign busy = s_reg.busy;
   assign write_done = s_reg.done;
   assign high_byte_sel = s_reg.hi;
   assign hold_bank = s_reg.bank;
endmodule : tbw_exec

/* tbw_exec_props.sv */
`timescale 1ns/1ps
// ****
// checker
// ****
module tbw_exec_props (
   input wire logic clk,
   input wire logic nrst,
   input wire logic instr_valid,
   input wire logic [15:0] instr_opcode,
   input wire logic ptr_load,
   input wire logic [20:0] table_pointer,
   input wire logic busy,
   input wire logic write_done,
   input wire logic high_byte_sel,
   input wire logic [63:0] hold_bank
);
   logic bz_reg;
   wire tk = instr_valid && instr_opcode[15:2] == 14'h0003 && !bz_reg && !ptr_load;
   wire [1:0] m = instr_opcode[1:0];
   always_ff @(posedge clk or negedge nrst) if (!nrst) bz_reg <= 1'b0; else bz_reg <= tk;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   property p_done; tk |-> ##1 busy && !write_done ##1 write_done && !busy; endproperty
   property p_keep; tk && m == 2'h0 |-> ##2 table_pointer == $past(table_pointer, 2); endproperty
   property p_inc; tk && m == 2'h1 |-> ##2 table_pointer == $past(table_pointer, 2) + 21'h000001; endproperty
   property p_dec; tk && m == 2'h2 |-> ##2 table_pointer == $past(table_pointer, 2) - 21'h000001; endproperty
   property p_pre;
      tk && m == 2'h3 |-> ##2 table_pointer == $past(table_pointer, 2) + 21'h000001
         && high_byte_sel == table_pointer[0];
   endproperty
   property p_hsel; tk && m != 2'h3 |-> ##2 high_byte_sel == $past(table_pointer[0], 2); endproperty
   property p_bank; !$stable(hold_bank) |-> $past(tk, 4); endproperty
   a_done: assert property (p_done) else $error("done timing");
   a_keep: assert property (p_keep) else $error("keep mode");
   a_inc: assert property (p_inc) else $error("post increment");
   a_dec: assert property (p_dec) else $error("post decrement");
   a_pre: assert property (p_pre) else $error("pre increment");
   a_hsel: assert property (p_hsel) else $error("byte select");
   a_bank: assert property (p_bank) else $error("bank change");
   c_pre: cover property (tk && m == 2'h3);
   c_dec: cover property (tk && m == 2'h2);
   c_done: cover property (write_done);
endmodule : tbw_exec_props
bind tbw_exec tbw_exec_props u_props (.clk(clk), .nrst(nrst), .instr_valid(instr_valid), .instr_opcode(instr_opcode),
   .ptr_load(ptr_load), .table_pointer(table_pointer), .busy(busy), .write_done(write_done),
   .high_byte_sel(high_byte_sel), .hold_bank(hold_bank));

/* tbw_hold_bank.sv */
`timescale 1ns/1ps
module tbw_hold_bank (
   input wire logic clk,
   input wire logic rst_n,
   tbw_hold_if.hold hif
);
   // ****************************************
   // holding register array
   // ****************************************
   typedef struct packed {
      logic [tbw_pkg::HOLD_N-1:0][7:0] mem;
   } tbw_bank_t;

   tbw_bank_t s_reg;
   tbw_bank_t s_next;

   always_comb begin
      s_next = s_reg;
      if (hif.wr) begin
         s_next.mem[hif.sel] = hif.data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign hif.bank = s_reg.mem;
endmodule : tbw_hold_bank

/* tbw_hold_if.sv */
`timescale 1ns/1ps
interface tbw_hold_if;
   logic wr;
   logic [tbw_pkg::SEL_W-1:0] sel;
   logic [7:0] data;
   logic [8*tbw_pkg::HOLD_N-1:0] bank;
   modport exec (output wr, output sel, output data, input bank);
   modport hold (input wr, input sel, input data, output bank);
endinterface : tbw_hold_if

/* tbw_pkg.sv */
package tbw_pkg;
   // ****************************************
   // widths and counts
   // ****************************************
   localparam int PTR_W = 21;
   localparam int SEL_W = 3;
   localparam int HOLD_N = 8;
   localparam logic [PTR_W-1:0] PTR_RST = 21'h000000;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [PTR_W-1:0] PTR_ONE = 21'h000001;
   localparam logic [11:0] OPC_UPPER = 12'h000;
   localparam logic [1:0] OPC_WR_TAG = 2'h3;

   // ****************************************
   // pointer update modes
   // ****************************************
   typedef enum logic [1:0] {
      TBW_KEEP = 2'h0,
      TBW_POST_INC = 2'h1,
      TBW_POST_DEC = 2'h2,
      TBW_PRE_INC = 2'h3
   } tbw_mode_t;

   typedef enum logic [1:0] {
      TBW_IDLE = 2'h0,
      TBW_EXEC = 2'h1
   } tbw_state_t;
endpackage : tbw_pkg

/* test_table_write_executor.sv */
`timescale 1ns/1ps
// ****
// bench
// ****
module test_table_write_executor;
   logic clk = 0, nrst = 0, iv = 0, ld = 0, we = 0, busy, done, hs;
   logic [15:0] op = 16'h0000;
   logic [7:0] lat = 8'h00, d = 8'h00;
   logic [20:0] lv = 21'h000000, ptr, xp = 21'h000000;
   logic [2:0] sel = 3'h0;
   logic [63:0] bank, rbank;
   int n_errors = 0, n_tests = 0, cyc = 0;
   tbw_exec DUT (.clk(clk), .nrst(nrst), .instr_valid(iv), .instr_opcode(op), .table_latch_byte(lat), .ptr_load(ld),
      .ptr_load_value(lv), .table_pointer(ptr), .busy(busy), .write_done(done), .high_byte_sel(hs), .hold_bank(bank));
   tbw_bank_ref ref_bank (.clk(clk), .we(we), .sel(sel), .d(d), .bank(rbank));
   initial forever #2.5 clk = ~clk;
   always @(posedge clk) if (++cyc > 500) begin
      n_errors++;
      print_verdict();
   end
   task print_verdict;
      if (n_errors == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : print_verdict
   task chk(input string s, input logic [63:0] e, input logic [63:0] g);
      n_tests++;
      if (e !== g) begin
         n_errors++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task wr(input logic [1:0] m, input logic [7:0] b, input logic h);
      logic [20:0] a;
      a = (m == 2'h3) ? xp + 21'h000001 : xp;
      xp = (m == 2'h0) ? xp : (m == 2'h2) ? xp - 21'h000001 : xp + 21'h000001;
      @(posedge clk);
      iv <= 1'b1;
      op <= {14'h0003, m};
      lat <= b;
      @(posedge clk);
      iv <= h;
      #1;
      chk("busy", 64'h1, busy);
      @(posedge clk);
      iv <= 1'b0;
      #1;
      chk("done", 64'h1, done);
      chk("busy_end", 64'h0, busy);
      chk("pointer", xp, ptr);
      chk("byte_sel", a[0], hs);
      we <= 1'b1;
      sel <= a[2:0];
      d <= b;
      @(posedge clk);
      we <= 1'b0;
      @(posedge clk);
      #1;
      chk("hold_bank", rbank, bank);
   endtask : wr
   task ld_ptr(input logic [20:0] v);
      @(posedge clk);
      ld <= 1'b1;
      lv <= v;
      @(posedge clk);
      ld <= 1'b0;
      xp = v;
      #1;
      chk("load", v, ptr);
   endtask : ld_ptr
   task t_wrap;
      ld_ptr(21'h1FFFFF);
      wr(2'h1, 8'hA5, 1'b0);
      wr(2'h2, 8'h3C, 1'b0);
   endtask : t_wrap
   task t_modes;
      for (int i = 0; i < 4; i++) wr(i[1:0], 8'h5A ^ i[7:0], 1'b0);
   endtask : t_modes
   task t_refuse;
      wr(2'h1, 8'hC3, 1'b1);
   endtask : t_refuse
   task t_fill;
      ld_ptr(21'h000003);
      for (int i = 0; i < 8; i++) wr(2'h1, 8'h10 + i[7:0], 1'b0);
   endtask : t_fill
   initial begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      t_wrap();
      t_modes();
      t_refuse();
      t_fill();
      print_verdict();
   end
endmodule : test_table_write_executor
